/* File: seiu_pkg.sv */
// package: register map, field positions and types for the status endpoint interrupt unit
package seiu_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SEIU_OFS_ENABLE_LOW  = 8'h20;
  localparam logic [7:0] SEIU_OFS_ENABLE_HIGH = 8'h24;
  localparam logic [7:0] SEIU_OFS_STATUS_LOW  = 8'h28;
  localparam logic [7:0] SEIU_OFS_MODE        = 8'h3C;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [31:0] SEIU_RST_ENABLE   = 32'h0000_0000;
  localparam logic [31:0] SEIU_RST_STATUS   = 32'h0000_0000;
  localparam logic [31:0] SEIU_WMASK_EN_LOW = 32'h001E_0D9F;
  localparam logic [31:0] SEIU_W1C_MASK     = 32'h0000_0D80;
  localparam logic [1:0]  SEIU_RST_MODE     = 2'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEIU_BIT_EP0        = 0;
  localparam int SEIU_BIT_GEP_OUT0   = 1;
  localparam int SEIU_BIT_SETUP      = 7;
  localparam int SEIU_BIT_TLP_DRAIN  = 8;
  localparam int SEIU_BIT_CFG_RETRY  = 10;
  localparam int SEIU_BIT_IN_TIMEOUT = 11;
  localparam int SEIU_BIT_GEP_IN0    = 17;
  localparam int SEIU_BIT_GLOBAL     = 31;
  localparam int SEIU_NUM_GEP        = 4;

  // operating mode of the controller
  typedef enum logic [1:0] {
    SEIU_MODE_ROOT_COMPLEX = 2'h0,
    SEIU_MODE_LEGACY_ADAPT = 2'h1,
    SEIU_MODE_ENH_ADAPT    = 2'h2
  } seiu_mode_t;

  // level sources that feed the low enable register
  typedef struct packed {
    logic                    ep0;
    logic [SEIU_NUM_GEP-1:0] gepOut;
    logic [SEIU_NUM_GEP-1:0] gepIn;
  } seiu_ep_irq_t;

  // one-cycle pulses that set the sticky low status bits
  typedef struct packed {
    logic setupPkt;
    logic tlpDrained;
    logic cfgRetry;
    logic inTimeout;
  } seiu_ev_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } seiu_req_t;

endpackage : seiu_pkg

/* File: seiu_status_endpoint_irq.sv */
// status endpoint interrupt unit: enable masks, low status register, interrupt request
//
// Operation
// RL1: enable registers act only in root-complex mode; reserved in adapter modes.
// RL2: high enable bit 0 gates start-of-frame, bit 1 gates resume.
// RL3: bit 2 gates suspend-request change, bit 3 gates suspend request.
// RL4: bit 4 gates host port reset.
// RL5: bit 6 gates control status stage token.
// RL6: bit 7 gates bus-power sense change.
// RL7: bit 8 gates serial EEPROM transaction done.
// RL8: bits 9..12 gate DMA channels 0..3, bit 13 gates GPIO.
// RL9: bit 14 gates start-of-frame with frame downcount at zero.
// RL10: bit 16 gates PCI Express TLP completion.
// RL11: bits 19, 20, 25 gate completer abort, unsupported request, poisoned TLP.
// RL12: bits 21, 22, 23 gate correctable, non-fatal, fatal error messages.
// RL13: bits 24 and 26 gate legacy interrupt input in root-complex mode.
// RL14: bit 27 gates power-state field change.
// RL15: bits 28, 29, 30 gate data-link-down change, hot reset, endpoint power.
// RL16: bit 31 is global enable; no interrupt without it.
// RL17: low enable bits 17..20 gate endpoint IN 0..3, bit 11 IN timeout.
// RL18: low status bits 0..4 mirror endpoint interrupts regardless of enables.
// RL19: legacy adapter merges OUT and IN per bit; enhanced reports OUT only.
// RL20: status bit 7 set on setup packet, cleared by writing one.
// RL21: status bit 8 set when USB-to-PCIe TLP transmitted, write one clears.
// RL22: status bits 10, 11 flag config retry and IN timeout; write one clears.
// RL23: request raised while any enabled event active and global enable set.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns

module seiu_status_endpoint_irq
  import seiu_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clkEn,
  input  wire seiu_req_t    regReq,
  output logic [31:0]       regRdata,
  input  wire seiu_ep_irq_t epIrq,
  input  wire seiu_ev_t     statusEv,
  input  wire logic [31:0]  highEvents,
  output logic              statusIrqReq
);

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  logic [1:0] mode_r;
  logic       rootMode;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_r <= SEIU_RST_MODE;
    end else if (clkEn && regReq.wr && regReq.addr == SEIU_OFS_MODE) begin
      mode_r <= regReq.wdata[1:0];
    end
  end

  assign rootMode = (mode_r == SEIU_MODE_ROOT_COMPLEX);

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  logic [31:0] enLow_r;
  logic [31:0] enHigh_r;

  // writes outside root-complex mode are dropped: registers behave as reserved
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enLow_r <= SEIU_RST_ENABLE;
    end else if (clkEn && rootMode && regReq.wr && regReq.addr == SEIU_OFS_ENABLE_LOW) begin // RL1
      enLow_r <= regReq.wdata & SEIU_WMASK_EN_LOW;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enHigh_r <= SEIU_RST_ENABLE;
    end else if (clkEn && rootMode && regReq.wr && regReq.addr == SEIU_OFS_ENABLE_HIGH) begin // RL1
      enHigh_r <= regReq.wdata;
    end
  end

  // ----------------------------------------------------------------
  // low status register
  // ----------------------------------------------------------------
  logic [SEIU_NUM_GEP-1:0] gepView;
  logic [3:0]              stickySet;
  logic [3:0]              stickyClr;
  logic [3:0]              sticky_r;
  logic [31:0]             statusLow;

  // per-endpoint view depends on adapter flavour
  genvar g;
  generate
    for (g = 0; g < SEIU_NUM_GEP; g++) begin : g_gep
      assign gepView[g] = (mode_r == SEIU_MODE_ENH_ADAPT) ? epIrq.gepOut[g] :
                          (epIrq.gepOut[g] | epIrq.gepIn[g]); // RL19
    end
  endgenerate

  assign stickySet = {statusEv.inTimeout, statusEv.cfgRetry,
                      statusEv.tlpDrained, statusEv.setupPkt};

  function automatic logic [3:0] w1cBits(input logic [31:0] d);
    w1cBits = {d[SEIU_BIT_IN_TIMEOUT], d[SEIU_BIT_CFG_RETRY],
               d[SEIU_BIT_TLP_DRAIN], d[SEIU_BIT_SETUP]};
  endfunction : w1cBits

  assign stickyClr = (regReq.wr && regReq.addr == SEIU_OFS_STATUS_LOW) ?
                     w1cBits(regReq.wdata) : 4'h0;

  // a set in the same cycle as its clear wins so the event is not lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sticky_r <= SEIU_RST_STATUS[3:0];
    end else if (clkEn) begin
      sticky_r <= (sticky_r & ~stickyClr) | stickySet; // RL20 RL21 RL22
    end
  end

  always_comb begin
    statusLow                      = 32'h0000_0000;
    statusLow[SEIU_BIT_EP0]        = epIrq.ep0; // RL18
    statusLow[4:1]                 = gepView; // RL18
    statusLow[SEIU_BIT_SETUP]      = sticky_r[0];
    statusLow[SEIU_BIT_TLP_DRAIN]  = sticky_r[1];
    statusLow[SEIU_BIT_CFG_RETRY]  = sticky_r[2];
    statusLow[SEIU_BIT_IN_TIMEOUT] = sticky_r[3];
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  logic [31:0] lowSrc;
  logic        anyEnabled;
  logic        irq_r;

  // low enable sources: status bits 0..11 plus endpoint IN 0..3
  always_comb begin
    lowSrc                                     = statusLow;
    lowSrc[SEIU_BIT_GEP_IN0+:SEIU_NUM_GEP]     = epIrq.gepIn; // RL17
  end

  // bit 31 of the event vector is unused; the global enable gates instead
  assign anyEnabled = |(lowSrc & enLow_r) |
                      |(highEvents[30:0] & enHigh_r[30:0]); // RL2 RL3 RL4 RL5 RL6 RL7 RL8 RL9 RL10 RL11 RL12 RL13 RL14 RL15

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else if (clkEn) begin
      irq_r <= rootMode && enHigh_r[SEIU_BIT_GLOBAL] && anyEnabled; // RL16 RL23
    end
  end

  assign statusIrqReq = irq_r;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdata <= 32'h0000_0000;
      if (regReq.rd) begin
        case (regReq.addr)
          SEIU_OFS_ENABLE_LOW:  regRdata <= rootMode ? enLow_r : 32'h0000_0000;
          SEIU_OFS_ENABLE_HIGH: regRdata <= rootMode ? enHigh_r : 32'h0000_0000;
          SEIU_OFS_STATUS_LOW:  regRdata <= statusLow;
          SEIU_OFS_MODE:        regRdata <= {30'h0, mode_r};
          default:              regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  global_gate_a: assert property ( // RL16
    clkEn && !enHigh_r[SEIU_BIT_GLOBAL] |=> !statusIrqReq)
    else $error("interrupt raised without global enable");

  irq_raise_a: assert property ( // RL23
    clkEn && rootMode && enHigh_r[SEIU_BIT_GLOBAL] && anyEnabled |=> statusIrqReq)
    else $error("enabled event did not raise interrupt");

  irq_drop_a: assert property ( // RL23
    clkEn && !anyEnabled |=> !statusIrqReq)
    else $error("interrupt stayed with no enabled event");

  adapter_lock_a: assert property ( // RL1
    !rootMode |=> $stable(enHigh_r) && $stable(enLow_r))
    else $error("enable changed outside root-complex mode");

  ep_mirror_a: assert property ( // RL18
    statusLow[SEIU_BIT_EP0] == epIrq.ep0)
    else $error("endpoint 0 status not mirrored");

  enh_out_only_a: assert property ( // RL19
    mode_r == SEIU_MODE_ENH_ADAPT |-> statusLow[4:1] == epIrq.gepOut)
    else $error("enhanced mode status not OUT only");

  setup_set_a: assert property ( // RL20
    clkEn && statusEv.setupPkt |=> statusLow[SEIU_BIT_SETUP])
    else $error("setup event lost");

  drain_clear_a: assert property ( // RL21
    clkEn && stickyClr[1] && !statusEv.tlpDrained |=> !statusLow[SEIU_BIT_TLP_DRAIN])
    else $error("drain flag not cleared by write one");

  retry_hold_a: assert property ( // RL22
    clkEn && sticky_r[2] && !stickyClr[2] |=> sticky_r[2])
    else $error("retry flag dropped without clear");

  // read-side views: what software sees must match the state one cycle earlier
  status_read_a: assert property ( // RL18
    clkEn && regReq.rd && regReq.addr == SEIU_OFS_STATUS_LOW |=>
      regRdata == $past(statusLow))
    else $error("status read does not return status bits");

  rdata_idle_a: assert property (
    clkEn && !regReq.rd |=> regRdata == 32'h0000_0000)
    else $error("read data not zero outside read cycle");

  enlow_mask_a: assert property ( // RL17
    clkEn && rootMode && regReq.wr && regReq.addr == SEIU_OFS_ENABLE_LOW |=>
      enLow_r == ($past(regReq.wdata) & SEIU_WMASK_EN_LOW))
    else $error("low enable write not masked");

  timeout_set_a: assert property ( // RL22
    clkEn && statusEv.inTimeout |=> sticky_r[3])
    else $error("timeout event lost against clear");

  adapter_quiet_a: assert property ( // RL1
    clkEn && !rootMode |=> !statusIrqReq)
    else $error("interrupt raised outside root-complex mode");

  cover_irq_c: cover property (clkEn && !statusIrqReq ##1 statusIrqReq);
  cover_enh_c: cover property (mode_r == SEIU_MODE_ENH_ADAPT && (|epIrq.gepIn));
  cover_clr_c: cover property (clkEn && sticky_r[0] ##1 stickyClr[0] ##1 !sticky_r[0]);
  cover_race_c: cover property (clkEn && stickySet[3] && stickyClr[3]);

endmodule : seiu_status_endpoint_irq

/* File: seiu_host_model.sv */
// host side of the status interrupt endpoint: counts interrupt requests it is handed
`timescale 1ns/1ns

module seiu_host_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       statusIrqReq,
  output logic      [7:0] irqCount_r
);
  // ----------------------------------------------------------------
  // request edge counter
  // ----------------------------------------------------------------
  logic irqPrev_r;

  // the request is a level, so only its rising edge counts as a new interrupt
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqPrev_r  <= 1'h0;
      irqCount_r <= 8'h00;
    end else begin
      irqPrev_r <= statusIrqReq;
      if (statusIrqReq && !irqPrev_r) begin
        irqCount_r <= irqCount_r + 8'h01;
      end
    end
  end
endmodule : seiu_host_model

/* File: seiu_status_endpoint_irq_tb.sv */
// testbench for the status endpoint interrupt unit
`timescale 1ns/1ns

module seiu_status_endpoint_irq_tb;
  import seiu_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic         clk;
  logic         sysRst;
  logic         clkEn;
  seiu_req_t    req;
  logic [31:0]  rdata;
  seiu_ep_irq_t epIrq;
  seiu_ev_t     ev;
  logic [31:0]  hev;
  logic         irq;
  logic [7:0]   irqCount;
  logic [31:0]  got;
  int           errCount;
  int           checkCount;
  logic [7:0]   addrs [5] = '{8'h20, 8'h24, 8'h28, 8'h3C, 8'h10};

  seiu_status_endpoint_irq i_dut (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .regReq(req),
    .regRdata(rdata), .epIrq(epIrq), .statusEv(ev), .highEvents(hev), .statusIrqReq(irq));
  seiu_host_model i_host (.clk(clk), .sys_rst(sysRst), .statusIrqReq(irq), .irqCount_r(irqCount));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk) req.wr <= 1'h0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge clk) req.rd <= 1'h0;
    #1 d = rdata;
  endtask : rd

  task automatic chkReg(input logic [7:0] a, input logic [31:0] exp);
    rd(a, got);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t reg %h read %h expected %h", $time, a, got, exp);
    end
  endtask : chkReg

  // the request follows its cause one cycle later, so two edges settle it
  task automatic chkIrq(input logic exp);
    repeat (2) @(posedge clk);
    #1 checkCount++;
    if (irq !== exp) begin
      errCount++;
      $display("[ERR] %0t interrupt request %b expected %b", $time, irq, exp);
    end
  endtask : chkIrq

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    sysRst = 1'h1;
    clkEn  = 1'h1;
    req    = '0;
    epIrq  = '0;
    ev     = '0;
    hev    = 32'h0;
    errCount = 0;
    checkCount = 0;
    repeat (2) @(posedge clk);
    sysRst <= 1'h0;
    foreach (addrs[i]) chkReg(addrs[i], 32'h0);
    $display("reset values done");
    wr(SEIU_OFS_ENABLE_HIGH, 32'hFFFF_FFFF);
    chkReg(SEIU_OFS_ENABLE_HIGH, 32'hFFFF_FFFF);
    wr(SEIU_OFS_ENABLE_LOW, 32'hFFFF_FFFF);
    chkReg(SEIU_OFS_ENABLE_LOW, 32'h001E_0D9F);
    wr(SEIU_OFS_ENABLE_LOW, 32'h0);
    $display("enable access done");
    for (int b = 0; b < 31; b++) begin
      @(posedge clk) hev <= 32'h1 << b;
      wr(SEIU_OFS_ENABLE_HIGH, 32'h8000_0000 | (32'h1 << b));
      chkIrq(1'h1);
      wr(SEIU_OFS_ENABLE_HIGH, 32'h1 << b);
      chkIrq(1'h0);
    end
    checkCount++;
    if (irqCount !== 8'd31) begin
      errCount++;
      $display("[ERR] %0t host saw %0d interrupts", $time, irqCount);
    end
    $display("high events done");
    @(posedge clk) hev <= 32'h1;
    wr(SEIU_OFS_ENABLE_HIGH, 32'h8000_0001);
    epIrq <= '{ep0: 1'h1, gepOut: 4'b0101, gepIn: 4'b0010};
    chkIrq(1'h1);
    chkReg(SEIU_OFS_STATUS_LOW, 32'h0000_000F);
    for (int m = 1; m < 3; m++) begin
      wr(SEIU_OFS_MODE, m);
      chkIrq(1'h0);
      chkReg(SEIU_OFS_ENABLE_HIGH, 32'h0);
      wr(SEIU_OFS_ENABLE_HIGH, 32'hFFFF_FFFF);
      chkReg(SEIU_OFS_STATUS_LOW, (m == 2) ? 32'h0000_000B : 32'h0000_000F);
    end
    wr(SEIU_OFS_MODE, 32'h0);
    chkReg(SEIU_OFS_ENABLE_HIGH, 32'h8000_0001);
    $display("modes done");
    @(posedge clk) hev <= 32'h0;
    wr(SEIU_OFS_ENABLE_HIGH, 32'h8000_0000);
    wr(SEIU_OFS_ENABLE_LOW, 32'h0004_0000);
    chkIrq(1'h1);
    wr(SEIU_OFS_ENABLE_HIGH, 32'h0);
    chkIrq(1'h0);
    @(posedge clk) epIrq <= '0;
    wr(SEIU_OFS_ENABLE_HIGH, 32'h8000_0000);
    wr(SEIU_OFS_ENABLE_LOW, 32'h0000_0800);
    chkIrq(1'h0);
    @(posedge clk) ev <= 4'hF;
    @(posedge clk) ev <= 4'h0;
    chkIrq(1'h1);
    chkReg(SEIU_OFS_STATUS_LOW, 32'h0000_0D80);
    wr(SEIU_OFS_STATUS_LOW, 32'h0000_0080);
    chkReg(SEIU_OFS_STATUS_LOW, 32'h0000_0D00);
    wr(SEIU_OFS_STATUS_LOW, 32'h0000_0D00);
    chkReg(SEIU_OFS_STATUS_LOW, 32'h0);
    chkIrq(1'h0);
    $display("status clear done");
    // a frozen clock enable must drop a write entirely
    @(posedge clk) clkEn <= 1'h0;
    wr(SEIU_OFS_ENABLE_HIGH, 32'h0000_0001);
    @(posedge clk) clkEn <= 1'h1;
    chkReg(SEIU_OFS_ENABLE_HIGH, 32'h8000_0000);
    $display("clock enable done");
    end_sim();
  end

  // the tests need under a thousand cycles, so this limit only trips on a hang
  initial begin
    #(20 * 5000);
    errCount++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule : seiu_status_endpoint_irq_tb
